// ### rpar_defines.vh
`ifndef RPAR_DEFINES_VH
`define RPAR_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPAR_OFS_RATE        8'h4b
`define RPAR_OFS_POWER       8'h4c
`define RPAR_OFS_CHAN        8'h4d
`define RPAR_OFS_UPREP       8'h50
`define RPAR_OFS_MAC         8'h51
`define RPAR_OFS_PORT        8'h52
`define RPAR_OFS_NET         8'h53
`define RPAR_OFS_ANN         8'h54
// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define RPAR_RST_RATE        8'h00
`define RPAR_RST_POWER       8'h01
`define RPAR_RST_CHAN        8'h00
`define RPAR_RST_UPREP       8'h00
`define RPAR_RST_MAC         8'h00
`define RPAR_RST_PORT        8'h01
`define RPAR_RST_NET         8'h00
`define RPAR_RST_ANN         8'h00
`define RPAR_MSK_RATE        8'h3f
`define RPAR_MSK_POWER       8'h07
// ----------------------------------------
// field positions
// ----------------------------------------
`define RPAR_F_TX_RATE       2:0
`define RPAR_F_RX2_RATE      5:3
`define RPAR_F_POWER         2:0
`define RPAR_F_TX_CHAN       3:0
`define RPAR_F_RX2_CHAN      7:4
`define RPAR_F_UNCONF        3:0
`define RPAR_F_CONF          7:4
`define RPAR_B_NET_ADR       2
`define RPAR_B_NET_ACHAN     4
`define RPAR_B_NET_ARX2      5
`define RPAR_F_ANN_SER       3:0
`define RPAR_F_ANN_UL        7:4
// ----------------------------------------
// codes
// ----------------------------------------
`define RPAR_SLOWEST_RATE_CODE   3'h0
`define RPAR_FAST_WIDE_RATE_CODE 3'h6
`define RPAR_FSK_RATE_CODE       3'h7
`define RPAR_SF_SLOWEST          4'hc
`define RPAR_SF_WIDE             4'h7
`define RPAR_SF_NONE             4'h0
`define RPAR_MAX_POWER_CODE      3'h1
`define RPAR_MIN_POWER_CODE      3'h5
`define RPAR_PWR_BASE_DBM        5'h11
`define RPAR_PWR_STEP_DB         5'h03
`define RPAR_FIRST_CHANNEL       4'h0
`define RPAR_NINTH_CHANNEL       4'h8
`define RPAR_MAC_LINK_CHECK      8'h02
`endif

// ### rpar_buf2.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-entry stream buffer, outputs from flops
// ----------------------------------------
module rpar_buf2 #(
  parameter W = 9
) (
  // clock and reset
  input  wire         mclk,
  input  wire         sys_rst,
  // fill side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  // drain side
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);
  reg [W-1:0] d0_q;
  reg [W-1:0] d1_q;
  reg         v0_q;
  reg         v1_q;
  reg         rdy_q;
  wire        push = in_valid & rdy_q;
  wire        pop  = v0_q & out_ready;
  reg         v0_d;
  reg         v1_d;
  always @* begin
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop) begin
      v0_d = v1_q | push;
      v1_d = v1_q & push;
    end else if (push) begin
      v0_d = 1'b1;
      v1_d = v0_q;
    end
  end
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      d0_q  <= {W{1'b0}};
      d1_q  <= {W{1'b0}};
      v0_q  <= 1'b0;
      v1_q  <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      v0_q  <= v0_d;
      v1_q  <= v1_d;
      // ready is precomputed so the fill side sees a flop, not a gate
      rdy_q <= ~v1_d;
      if (pop) begin
        d0_q <= v1_q ? d1_q : in_data;
        if (v1_q & push)
          d1_q <= in_data;
      end else if (push) begin
        if (v0_q)
          d1_q <= in_data;
        else
          d0_q <= in_data;
      end
    end
  end
  assign in_ready  = rdy_q;
  assign out_valid = v0_q;
  assign out_data  = d0_q;
endmodule
`default_nettype wire

// ### rpar_framer.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// adds size prefix and info/rssi/snr trailer
// ----------------------------------------
module rpar_framer (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // annotation selects and values
  input  wire [3:0]  ann_en,
  input  wire [7:0]  size,
  input  wire [7:0]  info,
  input  wire [15:0] rssi,
  input  wire [15:0] snr,
  // payload in
  input  wire        in_valid,
  input  wire [7:0]  in_data,
  input  wire        in_last,
  output reg         in_ready,
  // annotated out
  output reg         out_valid,
  output reg  [7:0]  out_data,
  output reg         out_last,
  input  wire        out_ready
);
  localparam ST_IDLE = 3'h0, ST_PRE = 3'h1, ST_BODY = 3'h2, ST_INFO = 3'h3;
  localparam ST_RSH = 3'h4, ST_RSL = 3'h5, ST_SNH = 3'h6, ST_SNL = 3'h7;
  reg [2:0]  st_q;
  reg [3:0]  en_q;
  reg [7:0]  size_q;
  reg [7:0]  info_q;
  reg [15:0] rssi_q;
  reg [15:0] snr_q;
  // trailer order is fixed: info, rssi, snr
  function [2:0] after;
    input [2:0] s;
    input [3:0] e;
    begin
      if (s == ST_BODY && e[1])
        after = ST_INFO;
      else if ((s == ST_BODY || s == ST_INFO) && e[2])
        after = ST_RSH;
      else if (s != ST_SNL && e[3])
        after = ST_SNH;
      else
        after = ST_IDLE;
    end
  endfunction
  always @* begin
    in_ready  = 1'b0;
    out_valid = 1'b1;
    out_data  = 8'h00;
    out_last  = 1'b0;
    case (st_q)
      ST_PRE:  out_data = size_q;
      ST_BODY: begin
        in_ready  = out_ready;
        out_valid = in_valid;
        out_data  = in_data;
        out_last  = in_last & (en_q[3:1] == 3'h0);
      end
      ST_INFO: begin
        out_data = info_q;
        out_last = (en_q[3:2] == 2'h0);
      end
      ST_RSH:  out_data = rssi_q[15:8];
      ST_RSL: begin
        out_data = rssi_q[7:0];
        out_last = ~en_q[3];
      end
      ST_SNH:  out_data = snr_q[15:8];
      ST_SNL: begin
        out_data = snr_q[7:0];
        out_last = 1'b1;
      end
      default: out_valid = 1'b0;
    endcase
  end
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= ST_IDLE;
      en_q   <= 4'h0;
      size_q <= 8'h00;
      info_q <= 8'h00;
      rssi_q <= 16'h0000;
      snr_q  <= 16'h0000;
    end else if (st_q == ST_IDLE) begin
      // selects and values freeze per frame so a write cannot tear one
      if (in_valid) begin
        en_q   <= ann_en;
        size_q <= size;
        info_q <= info;
        rssi_q <= rssi;
        snr_q  <= snr;
        st_q   <= ann_en[0] ? ST_PRE : ST_BODY;
      end
    end else if (out_valid & out_ready) begin
      case (st_q)
        ST_PRE:  st_q <= ST_BODY;
        ST_BODY: st_q <= in_last ? after(ST_BODY, en_q) : ST_BODY;
        ST_RSH:  st_q <= ST_RSL;
        ST_SNH:  st_q <= ST_SNL;
        default: st_q <= after(st_q, en_q);
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rpar_regs.v
// Summary of operation
// - fixed rate and power only when adr off
// - rate codes: sf12 to sf7, wide, fsk
// - fixed rx2 rate only when adaptive rx2 off
// - power codes 1..5 give 14 to 2 dbm
// - fixed tx channel when adaptive channel off
// - fixed rx2 channel when adaptive rx2 off
// - nonzero confirmed count overrides unconfirmed mode
// - limit emissions per frame by counts
// - code 0x02 adds link-check to every frame
// - port register gives application port
// - serial bit 0: size byte in front
// - serial bit 2: two rssi bytes appended
// - serial bit 3: two snr bytes appended
// - uplink bit 4: size byte in front
// - uplink bit 5: last info byte appended
// - uplink bit 6: two rssi bytes appended
// - uplink bit 7: two snr bytes appended
// - behaviour bits 2,4,5 select adaptive features
`timescale 1ns/1ps
`default_nettype none
`include "rpar_defines.vh"
module rpar_regs #(
  parameter [3:0] UNCONF_DEFAULT = 4'h1
) (
  // clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // decoded command port
  input  wire        cmd_wr,
  input  wire        cmd_rd,
  input  wire [7:0]  cmd_addr,
  input  wire [7:0]  cmd_wdata,
  output wire [7:0]  cmd_rdata,
  output wire        cmd_ack,
  // settings asked for by the network
  input  wire [2:0]  net_tx_rate,
  input  wire [2:0]  net_tx_power,
  input  wire [3:0]  net_tx_channel,
  input  wire [2:0]  net_rx2_rate,
  input  wire [3:0]  net_rx2_channel,
  // effective radio settings
  output wire [2:0]  tx_rate,
  output wire [3:0]  tx_sf,
  output wire        tx_wide,
  output wire        tx_fsk,
  output wire [2:0]  tx_power,
  output wire [4:0]  tx_power_dbm,
  output wire [3:0]  tx_channel,
  output wire [2:0]  rx2_rate,
  output wire [3:0]  rx2_sf,
  output wire [3:0]  rx2_channel,
  // uplink control
  input  wire        ul_start,
  input  wire        ul_tx_done,
  input  wire        ul_ack,
  output wire        ul_confirmed,
  output wire        ul_resend,
  output wire        ul_frame_end,
  output wire        mac_link_check,
  output wire [7:0]  app_port,
  // reception metadata
  input  wire        rx_meta_stb,
  input  wire [7:0]  rx_meta_size,
  input  wire [7:0]  rx_meta_info,
  input  wire [15:0] rx_meta_rssi,
  input  wire [15:0] rx_meta_snr,
  // received payload in, serial out
  input  wire        rx_in_valid,
  input  wire [7:0]  rx_in_data,
  input  wire        rx_in_last,
  output wire        rx_in_ready,
  output wire        ser_valid,
  output wire [7:0]  ser_data,
  output wire        ser_last,
  input  wire        ser_ready,
  // uplink payload in, radio out
  input  wire        ul_in_valid,
  input  wire [7:0]  ul_in_data,
  input  wire        ul_in_last,
  input  wire [7:0]  ul_size,
  output wire        ul_in_ready,
  output wire        rf_valid,
  output wire [7:0]  rf_data,
  output wire        rf_last,
  input  wire        rf_ready
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg [7:0] rate_q;
  reg [7:0] power_q;
  reg [7:0] chan_q;
  reg [7:0] uprep_q;
  reg [7:0] mac_q;
  reg [7:0] port_q;
  reg [7:0] net_q;
  reg [7:0] ann_q;
  reg [7:0] rdata_q;
  reg       ack_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_q  <= `RPAR_RST_RATE;
      power_q <= `RPAR_RST_POWER;
      chan_q  <= `RPAR_RST_CHAN;
      uprep_q <= `RPAR_RST_UPREP;
      mac_q   <= `RPAR_RST_MAC;
      port_q  <= `RPAR_RST_PORT;
      net_q   <= `RPAR_RST_NET;
      ann_q   <= `RPAR_RST_ANN;
    end else if (cmd_wr) begin
      case (cmd_addr)
        `RPAR_OFS_RATE:  rate_q  <= cmd_wdata & `RPAR_MSK_RATE;
        `RPAR_OFS_POWER: power_q <= cmd_wdata & `RPAR_MSK_POWER;
        `RPAR_OFS_CHAN:  chan_q  <= cmd_wdata;
        `RPAR_OFS_UPREP: uprep_q <= cmd_wdata;
        `RPAR_OFS_MAC:   mac_q   <= cmd_wdata;
        `RPAR_OFS_PORT:  port_q  <= cmd_wdata;
        `RPAR_OFS_NET:   net_q   <= cmd_wdata;
        `RPAR_OFS_ANN:   ann_q   <= cmd_wdata;
        default:         ;
      endcase
    end
  end
  // reads answer one cycle later; unknown offsets read zero
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= cmd_rd | cmd_wr;
      if (cmd_rd) begin
        case (cmd_addr)
          `RPAR_OFS_RATE:  rdata_q <= rate_q;
          `RPAR_OFS_POWER: rdata_q <= power_q;
          `RPAR_OFS_CHAN:  rdata_q <= chan_q;
          `RPAR_OFS_UPREP: rdata_q <= uprep_q;
          `RPAR_OFS_MAC:   rdata_q <= mac_q;
          `RPAR_OFS_PORT:  rdata_q <= port_q;
          `RPAR_OFS_NET:   rdata_q <= net_q;
          `RPAR_OFS_ANN:   rdata_q <= ann_q;
          default:         rdata_q <= 8'h00;
        endcase
      end
    end
  end
  // ----------------------------------------
  // effective radio settings
  // ----------------------------------------
  wire       adr_on   = net_q[`RPAR_B_NET_ADR];
  wire       achan_on = net_q[`RPAR_B_NET_ACHAN];
  wire       arx2_on  = net_q[`RPAR_B_NET_ARX2];
  wire [2:0] tx_rate_c  = adr_on ? net_tx_rate : rate_q[`RPAR_F_TX_RATE];
  wire [2:0] tx_pwr_c   = adr_on ? net_tx_power : power_q[`RPAR_F_POWER];
  wire [3:0] tx_chan_c  = achan_on ? net_tx_channel : chan_q[`RPAR_F_TX_CHAN];
  wire [2:0] rx2_rate_c = arx2_on ? net_rx2_rate : rate_q[`RPAR_F_RX2_RATE];
  wire [3:0] rx2_chan_c = arx2_on ? net_rx2_channel : chan_q[`RPAR_F_RX2_CHAN];
  wire       pwr_ok  = (tx_pwr_c >= `RPAR_MAX_POWER_CODE) && (tx_pwr_c <= `RPAR_MIN_POWER_CODE);
  wire       tch_ok  = (tx_chan_c <= `RPAR_NINTH_CHANNEL);
  wire       rch_ok  = (rx2_chan_c <= `RPAR_NINTH_CHANNEL);
  // rate code to {spreading factor, wide band, fsk}
  function [5:0] rate_dec;
    input [2:0] c;
    begin
      case (c)
        `RPAR_FSK_RATE_CODE:       rate_dec = {`RPAR_SF_NONE, 1'b0, 1'b1};
        `RPAR_FAST_WIDE_RATE_CODE: rate_dec = {`RPAR_SF_WIDE, 1'b1, 1'b0};
        default:                   rate_dec = {`RPAR_SF_SLOWEST - {1'b0, c}, 1'b0, 1'b0};
      endcase
    end
  endfunction
  reg [2:0] tx_rate_q;
  reg [2:0] tx_pwr_q;
  reg [3:0] tx_chan_q;
  reg [2:0] rx2_rate_q;
  reg [3:0] rx2_chan_q;
  reg [5:0] tx_dec_q;
  reg [5:0] rx2_dec_q;
  reg [4:0] dbm_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_rate_q  <= `RPAR_SLOWEST_RATE_CODE;
      tx_pwr_q   <= `RPAR_MAX_POWER_CODE;
      tx_chan_q  <= `RPAR_FIRST_CHANNEL;
      rx2_rate_q <= `RPAR_SLOWEST_RATE_CODE;
      rx2_chan_q <= `RPAR_FIRST_CHANNEL;
      tx_dec_q   <= {`RPAR_SF_SLOWEST, 2'b00};
      rx2_dec_q  <= {`RPAR_SF_SLOWEST, 2'b00};
      dbm_q      <= `RPAR_PWR_BASE_DBM - `RPAR_PWR_STEP_DB;
    end else begin
      tx_rate_q  <= tx_rate_c;
      rx2_rate_q <= rx2_rate_c;
      // a reserved code keeps whatever was in force before
      if (pwr_ok)
        tx_pwr_q <= tx_pwr_c;
      if (tch_ok)
        tx_chan_q <= tx_chan_c;
      if (rch_ok)
        rx2_chan_q <= rx2_chan_c;
      tx_dec_q  <= rate_dec(tx_rate_q);
      rx2_dec_q <= rate_dec(rx2_rate_q);
      dbm_q     <= `RPAR_PWR_BASE_DBM - `RPAR_PWR_STEP_DB * {2'b00, tx_pwr_q};
    end
  end
  // ----------------------------------------
  // uplink emission count
  // ----------------------------------------
  reg       conf_q;
  reg       busy_q;
  reg [3:0] lim_q;
  reg [3:0] sent_q;
  reg       resend_q;
  reg       fend_q;
  wire [3:0] conf_cnt   = uprep_q[`RPAR_F_CONF];
  wire [3:0] unconf_cnt = uprep_q[`RPAR_F_UNCONF];
  wire [3:0] sent_nx    = sent_q + 4'h1;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      conf_q   <= 1'b0;
      busy_q   <= 1'b0;
      lim_q    <= UNCONF_DEFAULT;
      sent_q   <= 4'h0;
      resend_q <= 1'b0;
      fend_q   <= 1'b0;
    end else begin
      resend_q <= 1'b0;
      fend_q   <= 1'b0;
      if (ul_start) begin
        busy_q <= 1'b1;
        sent_q <= 4'h0;
        conf_q <= (conf_cnt != 4'h0);
        if (conf_cnt != 4'h0)
          lim_q <= conf_cnt;
        else
          lim_q <= (unconf_cnt == 4'h0) ? UNCONF_DEFAULT : unconf_cnt;
      end else if (busy_q & ul_tx_done) begin
        sent_q <= sent_nx;
        // a confirmed frame stops on its ack, any frame at its limit
        if ((conf_q & ul_ack) | (sent_nx >= lim_q)) begin
          busy_q <= 1'b0;
          fend_q <= 1'b1;
        end else begin
          resend_q <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // mac command and port
  // ----------------------------------------
  reg       lcheck_q;
  reg [7:0] port_out_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lcheck_q   <= 1'b0;
      port_out_q <= `RPAR_RST_PORT;
    end else begin
      lcheck_q   <= (mac_q == `RPAR_MAC_LINK_CHECK);
      port_out_q <= port_q;
    end
  end
  // ----------------------------------------
  // last reception metadata
  // ----------------------------------------
  reg [7:0]  lsize_q;
  reg [7:0]  linfo_q;
  reg [15:0] lrssi_q;
  reg [15:0] lsnr_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lsize_q <= 8'h00;
      linfo_q <= 8'h00;
      lrssi_q <= 16'h0000;
      lsnr_q  <= 16'h0000;
    end else if (rx_meta_stb) begin
      lsize_q <= rx_meta_size;
      linfo_q <= rx_meta_info;
      lrssi_q <= rx_meta_rssi;
      lsnr_q  <= rx_meta_snr;
    end
  end
  // ----------------------------------------
  // received frames toward the serial host
  // ----------------------------------------
  wire       rxb_v;
  wire [8:0] rxb_d;
  wire       rxb_r;
  wire       rxf_v;
  wire [7:0] rxf_d;
  wire       rxf_l;
  wire       rxf_r;
  wire [8:0] ser_w;
  rpar_buf2 #(.W(9)) u_rx_in (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (rx_in_valid),
    .in_data   ({rx_in_last, rx_in_data}),
    .in_ready  (rx_in_ready),
    .out_valid (rxb_v),
    .out_data  (rxb_d),
    .out_ready (rxb_r)
  );
  rpar_framer u_rx_frm (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .ann_en    (ann_q[`RPAR_F_ANN_SER]),
    .size      (lsize_q),
    .info      (linfo_q),
    .rssi      (lrssi_q),
    .snr       (lsnr_q),
    .in_valid  (rxb_v),
    .in_data   (rxb_d[7:0]),
    .in_last   (rxb_d[8]),
    .in_ready  (rxb_r),
    .out_valid (rxf_v),
    .out_data  (rxf_d),
    .out_last  (rxf_l),
    .out_ready (rxf_r)
  );
  rpar_buf2 #(.W(9)) u_ser_out (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (rxf_v),
    .in_data   ({rxf_l, rxf_d}),
    .in_ready  (rxf_r),
    .out_valid (ser_valid),
    .out_data  (ser_w),
    .out_ready (ser_ready)
  );
  // ----------------------------------------
  // uplink payload toward the radio
  // ----------------------------------------
  wire       ulb_v;
  wire [8:0] ulb_d;
  wire       ulb_r;
  wire       ulf_v;
  wire [7:0] ulf_d;
  wire       ulf_l;
  wire       ulf_r;
  wire [8:0] rf_w;
  // size does not pass through the buffer; the framer samples ul_size when the first byte reaches the buffer output
  rpar_buf2 #(.W(9)) u_ul_in (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (ul_in_valid),
    .in_data   ({ul_in_last, ul_in_data}),
    .in_ready  (ul_in_ready),
    .out_valid (ulb_v),
    .out_data  (ulb_d),
    .out_ready (ulb_r)
  );
  rpar_framer u_ul_frm (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .ann_en    (ann_q[`RPAR_F_ANN_UL]),
    .size      (ul_size),
    .info      (linfo_q),
    .rssi      (lrssi_q),
    .snr       (lsnr_q),
    .in_valid  (ulb_v),
    .in_data   (ulb_d[7:0]),
    .in_last   (ulb_d[8]),
    .in_ready  (ulb_r),
    .out_valid (ulf_v),
    .out_data  (ulf_d),
    .out_last  (ulf_l),
    .out_ready (ulf_r)
  );
  rpar_buf2 #(.W(9)) u_rf_out (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (ulf_v),
    .in_data   ({ulf_l, ulf_d}),
    .in_ready  (ulf_r),
    .out_valid (rf_valid),
    .out_data  (rf_w),
    .out_ready (rf_ready)
  );
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cmd_rdata      = rdata_q;
  assign cmd_ack        = ack_q;
  assign tx_rate        = tx_rate_q;
  assign tx_sf          = tx_dec_q[5:2];
  assign tx_wide        = tx_dec_q[1];
  assign tx_fsk         = tx_dec_q[0];
  assign tx_power       = tx_pwr_q;
  assign tx_power_dbm   = dbm_q;
  assign tx_channel     = tx_chan_q;
  assign rx2_rate       = rx2_rate_q;
  assign rx2_sf         = rx2_dec_q[5:2];
  assign rx2_channel    = rx2_chan_q;
  assign ul_confirmed   = conf_q;
  assign ul_resend      = resend_q;
  assign ul_frame_end   = fend_q;
  assign mac_link_check = lcheck_q;
  assign app_port       = port_out_q;
  assign ser_data       = ser_w[7:0];
  assign ser_last       = ser_w[8];
  assign rf_data        = rf_w[7:0];
  assign rf_last        = rf_w[8];
endmodule
`default_nettype wire

// ### rpar_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rpar_regs_properties (
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // register port
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic       cmd_ack,
  // radio settings
  input wire logic [2:0] net_tx_rate,
  input wire logic [2:0] tx_rate,
  input wire logic [3:0] tx_sf,
  input wire logic [2:0] tx_power,
  input wire logic [4:0] tx_power_dbm,
  input wire logic [2:0] rx2_rate,
  input wire logic       mac_link_check,
  // uplink control
  input wire logic       ul_tx_done,
  input wire logic       ul_resend,
  input wire logic       ul_frame_end
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow of rate and behaviour registers, so the checker knows the mode
  logic [7:0] rate_q;
  logic [7:0] net_q;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_q <= 8'h00;
      net_q  <= 8'h00;
    end else if (cmd_wr) begin
      if (cmd_addr == 8'h4b) rate_q <= cmd_wdata;
      if (cmd_addr == 8'h53) net_q <= cmd_wdata;
    end
  end
  sequence s_req;
    cmd_wr || cmd_rd;
  endsequence
  a_ack_follows: assert property (s_req |=> cmd_ack) else $error("no ack after request");
  a_ack_cause: assert property (cmd_ack |-> $past(cmd_wr || cmd_rd)) else $error("ack without request");
  a_fixed_rate: assert property (!net_q[2] |=> tx_rate == $past(rate_q[2:0]))
    else $error("fixed rate not applied");
  a_adr_rate: assert property (net_q[2] |=> tx_rate == $past(net_tx_rate))
    else $error("network rate not applied");
  a_rx2_fixed: assert property (!net_q[5] |=> rx2_rate == $past(rate_q[5:3]))
    else $error("fixed rx2 rate not applied");
  a_sf_decode: assert property (tx_sf == ($past(tx_rate) == 3'h7 ? 4'h0 :
    $past(tx_rate) == 3'h6 ? 4'h7 : 4'hc - {1'h0, $past(tx_rate)})) else $error("bad sf decode");
  a_power_dbm: assert property (tx_power_dbm == 5'h11 - 5'h03 * $past(tx_power))
    else $error("bad power level");
  a_link_check: assert property (cmd_wr && cmd_addr == 8'h51 |->
    ##2 mac_link_check == ($past(cmd_wdata, 2) == 8'h02)) else $error("link check flag wrong");
  a_end_cause: assert property (ul_resend || ul_frame_end |-> $past(ul_tx_done))
    else $error("uplink outcome without emission");
endmodule
bind rpar_regs rpar_regs_properties i_rpar_regs_properties (.mclk, .sys_rst, .cmd_wr, .cmd_rd,
  .cmd_addr, .cmd_wdata, .cmd_ack, .net_tx_rate, .tx_rate, .tx_sf, .tx_power, .tx_power_dbm,
  .rx2_rate, .mac_link_check, .ul_tx_done, .ul_resend, .ul_frame_end);
`default_nettype wire

// ### rpar_sink.sv
`timescale 1ns/1ps
`default_nettype none
module rpar_sink #(
  parameter bit SLOW = 1'h0
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // stream from the block
  input  wire logic       valid,
  input  wire logic [7:0] data,
  input  wire logic       last,
  output var  logic       ready
);
  logic [8:0] q[$];
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready <= 1'h0;
    end else begin
      // slow mode stalls every other cycle to exercise the buffers
      ready <= SLOW ? !ready : 1'h1;
      if (valid && ready) q.push_back({last, data});
    end
  end
endmodule
`default_nettype wire

// ### rpar_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rpar_regs_bench;
  logic mclk = 1'h0, sys_rst = 1'h1, cmd_wr = 1'h0, cmd_rd = 1'h0, ul_start = 1'h0, ul_tx_done = 1'h0;
  logic ul_ack = 1'h0, rx_meta_stb = 1'h0, rx_in_valid = 1'h0, rx_in_last = 1'h0;
  logic ul_in_valid = 1'h0, ul_in_last = 1'h0;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, rx_in_data = 8'h00, ul_in_data = 8'h00;
  logic [7:0] ul_size = 8'h02, rx_meta_size = 8'h02, rx_meta_info = 8'h11;
  logic [15:0] rx_meta_rssi = 16'ha1b2, rx_meta_snr = 16'hc3d4;
  logic [2:0] net_tx_rate = 3'h4, net_tx_power = 3'h2, net_rx2_rate = 3'h1;
  logic [3:0] net_tx_channel = 4'h6, net_rx2_channel = 4'h7;
  wire logic [7:0] cmd_rdata, app_port, ser_data, rf_data;
  wire logic cmd_ack, tx_wide, tx_fsk, ul_confirmed, ul_resend, ul_frame_end, mac_link_check;
  wire logic rx_in_ready, ser_valid, ser_last, ul_in_ready, rf_valid, rf_last, ser_ready, rf_ready;
  wire logic [2:0] tx_rate, tx_power, rx2_rate;
  wire logic [3:0] tx_sf, tx_channel, rx2_sf, rx2_channel;
  wire logic [4:0] tx_power_dbm;
  int mismatches = 0, num_checks = 0, cyc = 0;
  logic [7:0] rv[5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] mv[5] = '{8'h3f, 8'h07, 8'hff, 8'hff, 8'hff};
  logic [7:0] ofs[5] = '{8'h4b, 8'h4c, 8'h4d, 8'h51, 8'h54};
  logic [7:0] ex[8] = '{8'h02, 8'h40, 8'h41, 8'h11, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
  logic [8:0] got;
  rpar_regs i_rpar_regs (.*);
  rpar_sink #(.SLOW(1'h0)) i_ser_sink (.mclk, .sys_rst, .valid(ser_valid), .data(ser_data),
    .last(ser_last), .ready(ser_ready));
  rpar_sink #(.SLOW(1'h1)) i_rf_sink (.mclk, .sys_rst, .valid(rf_valid), .data(rf_data),
    .last(rf_last), .ready(rf_ready));
  always #25 mclk = ~mclk;
  // --------------------------------
  // checking and access tasks
  // --------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] g, e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ends once the slowest derived setting has landed
  task wr(input logic [7:0] a, d);
    @(posedge mclk);
    {cmd_wr, cmd_addr, cmd_wdata} <= {1'h1, a, d};
    @(posedge mclk);
    cmd_wr <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge mclk);
    {cmd_rd, cmd_addr} <= {1'h1, a};
    @(posedge mclk);
    cmd_rd <= 1'h0;
    #1;
    chk(cmd_ack, 1'h1);
    chk(cmd_rdata, e);
  endtask
  task ul(input logic s, a);
    @(posedge mclk);
    if (s) ul_start <= 1'h1;
    else {ul_tx_done, ul_ack} <= {1'h1, a};
    @(posedge mclk);
    {ul_start, ul_tx_done} <= 2'h0;
    #1;
  endtask
  task send(input logic u);
    logic r;
    @(posedge mclk);
    for (int i = 0; i < 2; i++) begin
      if (u) {ul_in_valid, ul_in_data, ul_in_last} <= {1'h1, 8'h40 + i[7:0], i == 1};
      else {rx_in_valid, rx_in_data, rx_in_last} <= {1'h1, 8'h40 + i[7:0], i == 1};
      do begin
        @(negedge mclk);
        r = u ? ul_in_ready : rx_in_ready;
        @(posedge mclk);
      end while (!r);
    end
    {ul_in_valid, rx_in_valid} <= 2'h0;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  // --------------------------------
  // test sequence
  // --------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'h0;
    for (int k = 0; k < 5; k++) rd(ofs[k], rv[k]);
    for (int k = 0; k < 5; k++) wr(ofs[k], 8'hff);
    for (int k = 0; k < 5; k++) rd(ofs[k], mv[k]);
    wr(8'h60, 8'h5a);
    rd(8'h60, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h4b, {2'h3, c[2:0], c[2:0]});
      chk(tx_rate, c[2:0]);
      chk({tx_sf, rx2_sf}, {2{c == 7 ? 4'h0 : c == 6 ? 4'h7 : 4'hc - c[3:0]}});
      chk({tx_wide, tx_fsk}, {c == 6, c == 7});
      chk(rx2_rate, c[2:0]);
    end
    for (int p = 1; p < 6; p++) begin
      wr(8'h4c, {5'h1f, p[2:0]});
      chk(tx_power_dbm, 5'h11 - 5'h03 * p[4:0]);
    end
    wr(8'h4c, 8'h00);
    chk(tx_power, 3'h5);
    wr(8'h4d, 8'h83);
    chk({tx_channel, rx2_channel}, 8'h38);
    wr(8'h4d, 8'h9a);
    chk({tx_channel, rx2_channel}, 8'h38);
    wr(8'h53, 8'h34);
    chk({tx_rate, tx_power}, 6'h22);
    chk({tx_channel, rx2_channel, rx2_rate}, 11'h339);
    wr(8'h53, 8'h00);
    chk(tx_channel, 4'h6);
    wr(8'h51, 8'h02);
    chk(mac_link_check, 1'h1);
    wr(8'h51, 8'h00);
    chk(mac_link_check, 1'h0);
    wr(8'h52, 8'h2a);
    chk(app_port, 8'h2a);
    wr(8'h50, 8'h02);
    ul(1'h1, 1'h0);
    chk(ul_confirmed, 1'h0);
    ul(1'h0, 1'h0);
    chk({ul_resend, ul_frame_end}, 2'h2);
    ul(1'h0, 1'h0);
    chk({ul_resend, ul_frame_end}, 2'h1);
    wr(8'h50, 8'h32);
    ul(1'h1, 1'h0);
    chk(ul_confirmed, 1'h1);
    ul(1'h0, 1'h0);
    chk({ul_resend, ul_frame_end}, 2'h2);
    ul(1'h0, 1'h1);
    chk({ul_resend, ul_frame_end}, 2'h1);
    // annotation register still 0xff: every prefix and trailer enabled
    @(posedge mclk);
    rx_meta_stb <= 1'h1;
    @(posedge mclk);
    rx_meta_stb <= 1'h0;
    for (int u = 0; u < 2; u++) begin
      send(u[0]);
      repeat (100) @(posedge mclk);
      chk(u ? i_rf_sink.q.size() : i_ser_sink.q.size(), 16'h0008);
      for (int k = 0; k < 8; k++) begin
        got = u ? i_rf_sink.q[k] : i_ser_sink.q[k];
        chk(got, {k == 7, ex[k]});
      end
    end
    final_report;
  end
endmodule
`default_nettype wire
